/* rtl/byte_queue.sv */
/*
  Word-wide storage for the 128-byte sample queue, flip-flop array with pointers.
  Pushes into a full queue and pops on empty are both ignored.
*/
`timescale 1ns/1ps
`include "sample_fifo_defs.svh"

module byte_queue (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        push,
  input  wire logic [15:0] push_data,
  input  wire logic        pop,
  input  wire logic        flush,
  output logic      [15:0] head_data,
  output logic      [6:0]  word_count
);

  logic [15:0]          mem_q [0:`QUEUE_WORDS-1];  // Storage words
  logic [`QUEUE_AW-1:0] wr_ptr_q;      // Next write slot
  logic [`QUEUE_AW-1:0] rd_ptr_q;      // Oldest word
  logic [6:0]           count_q;       // Words held
  logic                 do_push;       // Accepted push
  logic                 do_pop;        // Accepted pop

  // Full and empty guards keep the pointers honest
  assign do_push    = push & (count_q != `QUEUE_WORDS) & ~flush;
  assign do_pop     = pop & (count_q != 7'h00) & ~flush;
  assign head_data  = mem_q[rd_ptr_q];
  assign word_count = count_q;

  // Data storage needs no reset; pointers decide what is valid
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  // Pointers and occupancy; flush wins over push and pop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= 7'h00;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + {6'h00, do_push} - {6'h00, do_pop};
    end
  end

endmodule // byte_queue

/* rtl/sample_fifo_defs.svh */
/*
  Named constants for the sample queue and mode control block: register indices,
  field positions, reset values, format codes and sample clock timing.
  Assumes it is included by bare name from the design files and the bench.
*/
`ifndef SAMPLE_FIFO_DEFS_SVH
`define SAMPLE_FIFO_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_STATUS      7'h00
`define IDX_MASK        7'h01
`define IDX_THRESH      7'h06
`define IDX_MODE        7'h10
`define IDX_SELECT      7'h11
`define IDX_MODE_STAT   7'h12
`define IDX_CLKCTL      7'h4B
`define IDX_READ_PORT   7'h60

// Mode values
`define MODE_STANDBY    16'h0000
`define MODE_PROGRAM    16'h0001
`define MODE_NORMAL     16'h0002

// Field positions
`define CLK_EN_BIT      7
`define FLUSH_BIT       15
`define QUEUE_FLAG_BIT  7
`define QUEUE_MASK_BIT  8
`define THR_MSB         13
`define THR_LSB         8
`define SEL_A_MSB       3
`define SEL_A_LSB       0
`define SEL_B_MSB       7
`define SEL_B_LSB       4

// Reset values
`define MODE_RST        16'h0000
`define MASK_RST        16'hFFFF
`define THRESH_RST      16'h0000
`define SELECT_RST      16'h0000
`define CLKCTL_RST      16'h0000

// Per-slot format codes in the content select register
`define FMT_2B          4'h1
`define FMT_4B          4'h2
`define FMT_8B          4'h3
`define FMT_16B         4'h4

// Queue geometry: 64 words of 16 bits, 128 bytes
`define QUEUE_WORDS     7'h40
`define QUEUE_AW        6

// Sample clock timing
`define CORE_CLK_HZ     100000000
`define SAMPLE_CLK_HZ   32768
`define TICK_CYCLES     (`CORE_CLK_HZ / `SAMPLE_CLK_HZ)

`endif

/* rtl/sample_fifo_mode_control.sv */
/*
  Operating mode sequencer and 128-byte packet queue of a photometric front end,
  with a classic Wishbone register slave (one register per aligned 32-bit word).
  Assumes slot data and the output-rate event come from the time slot engine,
  all synchronous to core_clk.
*/
`timescale 1ns/1ps
`include "sample_fifo_defs.svh"

// Function
// RQ1 - Reset leaves mode zero and standby
// RQ2 - Transitions only on enabled sample clock ticks
// RQ3 - Mode one enters program once clock runs
// RQ4 - Host configures only while in program
// RQ5 - Mode two starts normal sampling
// RQ6 - Host stops via program, clear, standby
// RQ7 - Status bit fifteen write empties queue
// RQ8 - Clock disable outside standby locks sequencer
// RQ9 - Host disables clock only in standby
// RQ10 - 128-byte queue holds either or both slots
// RQ11 - Per-slot content select, or none
// RQ12 - Host shares queue only at equal rates
// RQ13 - One complete packet per output event
// RQ14 - Slot contributes 2, 4, 8, 16 bytes
// RQ15 - Whole packet stored or whole packet dropped
// RQ16 - Status upper byte shows bytes held
// RQ17 - Six-bit threshold sets queue flag level
// RQ18 - Mask bit one suppresses queue interrupt; the code uses mask bit eight
// RQ19 - Read clears flag; write above level sets
// RQ20 - Read port pops in order, frees space
// RQ21 - Host polls count, reads whole packets
// RQ22 - Host enters program then empties queue
// RQ23 - Illegal mode values leave mode unchanged
module sample_fifo_mode_control
  import sample_fifo_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [8:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         rate_event_i,
  input  wire logic [127:0] slot_a_data_i,
  input  wire logic [127:0] slot_b_data_i,
  output logic              irq_o,
  output logic              sampling_active_o
);

  // Words a slot adds to a packet for its format code
  function automatic logic [4:0] slot_words(input logic [3:0] code);
    case (code)
      `FMT_2B:  slot_words = 5'h01;
      `FMT_4B:  slot_words = 5'h02;
      `FMT_8B:  slot_words = 5'h04;
      `FMT_16B: slot_words = 5'h08;
      default:  slot_words = 5'h00;
    endcase
  endfunction

  // Byte-lane merge of a write into a 16-bit register
  function automatic reg16_t merge16(input reg16_t old, input logic [31:0] d, input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  logic [6:0]   idx;            // Register index
  logic         req;            // New bus request
  logic         wr;             // Write request
  logic         rd;             // Read request
  reg16_t       mask_q;         // Interrupt mask
  reg16_t       thresh_q;       // Threshold config
  reg16_t       mode_q;         // Requested mode
  reg16_t       select_q;       // Content select
  reg16_t       clkctl_q;       // Sample clock control
  reg16_t       wdata16;        // Merged write value
  op_state_t    state_q;        // Current mode
  logic         stuck_q;        // Sequencer locked
  logic         clk_en;         // Sample clock enable
  logic [11:0]  tick_cnt_q;     // Sample clock divider
  logic         tick_q;         // Sample clock edge
  logic         flag_q;         // Queue level flag
  logic         push_prev_q;    // Push seen last cycle
  logic [255:0] pkt_buf_q;      // Packet being stored
  logic [4:0]   pkt_left_q;     // Words still to store
  logic [4:0]   a_words;        // Slot A share
  logic [4:0]   b_words;        // Slot B share
  logic [4:0]   pkt_words;      // Whole packet size
  logic [7:0]   shamt;          // Bit offset of slot B
  logic [255:0] a_mask;         // Keeps slot A words
  logic [6:0]   word_count;     // Words held
  logic [6:0]   free_words;     // Room left
  logic [15:0]  head_data;      // Oldest queue word
  logic         pkt_start;      // Packet accepted
  logic         push;           // Word into queue
  logic         pop;            // Word out of queue
  logic         flush;          // Empty the queue
  logic         flag_set;       // Level crossed
  logic         flag_clr;       // Read or write-one
  logic         wb_ack_q;       // Bus answer
  logic [31:0]  wb_dat_q;       // Bus read data
  logic         irq_q;          // Interrupt output
  logic         active_q;       // Normal mode output
  logic [15:0]  rdata16;        // Read mux

  // Bus decode; ack blocks a second take of the same request
  assign idx     = wb_adr_i[8:2];
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign wr      = req & wb_we_i;
  assign rd      = req & ~wb_we_i;
  assign wdata16 = merge16(rdata16, wb_dat_i, wb_sel_i);
  assign clk_en  = clkctl_q[`CLK_EN_BIT];

  // Config registers; software may write them at any time here
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q   <= `MASK_RST;
      thresh_q <= `THRESH_RST;
      select_q <= `SELECT_RST;
      clkctl_q <= `CLKCTL_RST;
    end else if (wr) begin
      case (idx)
        `IDX_MASK:   mask_q   <= wdata16;
        `IDX_THRESH: thresh_q <= wdata16;
        `IDX_SELECT: select_q <= wdata16; // RQ11
        `IDX_CLKCTL: clkctl_q <= wdata16;
        default: ;                        // Others handled elsewhere
      endcase
    end
  end

  // Mode request; only 0, 1, 2 are stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `MODE_RST; // RQ1
    end else if (wr && idx == `IDX_MODE && wdata16 <= `MODE_NORMAL) begin
      mode_q <= wdata16; // RQ23
    end
  end

  // Sample clock divider, held in reset while disabled
  // Limitation: integer divide, so the tick runs slightly fast of nominal
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 12'h000;
      tick_q     <= 1'b0;
    end else if (!clk_en) begin
      tick_cnt_q <= 12'h000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 12'(`TICK_CYCLES - 1)) begin
      tick_cnt_q <= 12'h000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 12'h001;
      tick_q     <= 1'b0;
    end
  end

  // Lock: killing the clock outside standby freezes the sequencer until reset
  // No recovery path short of reset; software must keep the clock running
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stuck_q <= 1'b0;
    end else if (wr && idx == `IDX_CLKCTL && wb_sel_i[0] && !wb_dat_i[`CLK_EN_BIT] && state_q != ST_STANDBY) begin
      stuck_q <= 1'b1; // RQ8
    end
  end

  // Sequencer steps only on a sample clock edge; the live enable gates too,
  // so a tick already registered when software stops the clock moves nothing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_STANDBY; // RQ1
    end else if (tick_q && clk_en && !stuck_q) begin // RQ2 RQ8
      case (mode_q)
        `MODE_STANDBY: state_q <= ST_STANDBY;
        `MODE_PROGRAM: state_q <= ST_PROGRAM; // RQ3
        `MODE_NORMAL:  state_q <= ST_NORMAL;  // RQ5
        default:       state_q <= state_q;
      endcase
    end
  end

  // Packet sizing from the content select fields
  assign a_words    = slot_words(select_q[`SEL_A_MSB:`SEL_A_LSB]); // RQ14
  assign b_words    = slot_words(select_q[`SEL_B_MSB:`SEL_B_LSB]); // RQ14
  assign pkt_words  = a_words + b_words;
  assign shamt      = {a_words[3:0], 4'h0};
  assign a_mask     = ~(~256'h0 << shamt);
  assign free_words = `QUEUE_WORDS - word_count;
  assign flush      = wr && idx == `IDX_STATUS && wb_sel_i[1] && wb_dat_i[`FLUSH_BIT]; // RQ7

  // Accept only when the whole packet fits; else drop all of it
  assign pkt_start = rate_event_i && state_q == ST_NORMAL && pkt_left_q == 5'h00 && pkt_words != 5'h00
                     && !flush && {2'b00, pkt_words} <= free_words; // RQ15 RQ13
  assign push      = pkt_left_q != 5'h00 && !flush;

  // Serializer: slot A words first, then slot B, one word per cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pkt_buf_q  <= '0;
      pkt_left_q <= 5'h00;
    end else if (flush) begin
      pkt_left_q <= 5'h00; // RQ7
    end else if (pkt_start) begin
      pkt_buf_q  <= ({128'h0, slot_a_data_i} & a_mask) | ({128'h0, slot_b_data_i} << shamt); // RQ13
      pkt_left_q <= pkt_words;
    end else if (push) begin
      pkt_buf_q  <= {16'h0000, pkt_buf_q[255:16]};
      pkt_left_q <= pkt_left_q - 5'h01;
    end
  end

  // Reads of the data port pop in order
  assign pop = rd && idx == `IDX_READ_PORT; // RQ20

  byte_queue u_queue ( // RQ10
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .push       (push),
    .push_data  (pkt_buf_q[15:0]),
    .pop        (pop),
    .flush      (flush),
    .head_data  (head_data),
    .word_count (word_count)
  );

  // Level flag: a pop or write-one clears it, a push above level sets it and wins over a clear
  assign flag_set = push_prev_q && word_count > {1'b0, thresh_q[`THR_MSB:`THR_LSB]}; // RQ17 RQ19
  assign flag_clr = pop || (wr && idx == `IDX_STATUS && wb_sel_i[0] && wb_dat_i[`QUEUE_FLAG_BIT]);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      push_prev_q <= 1'b0;
      flag_q      <= 1'b0;
    end else begin
      push_prev_q <= push;
      flag_q      <= flag_set | (flag_q & ~flag_clr); // RQ19
    end
  end

  // Outputs, all registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q    <= 1'b0;
      active_q <= 1'b0;
    end else begin
      irq_q    <= flag_q & ~mask_q[`QUEUE_MASK_BIT]; // RQ18
      active_q <= (state_q == ST_NORMAL);
    end
  end

  // Read mux; unmapped indices read zero
  // Data is captured once per request, so a pop returns the word before it
  always_comb begin
    case (idx)
      `IDX_STATUS:    rdata16 = {word_count, 1'b0, flag_q, 7'h00}; // RQ16
      `IDX_MASK:      rdata16 = mask_q;
      `IDX_THRESH:    rdata16 = thresh_q;
      `IDX_MODE:      rdata16 = mode_q;
      `IDX_SELECT:    rdata16 = select_q;
      `IDX_MODE_STAT: rdata16 = {13'h0000, stuck_q, state_q};
      `IDX_CLKCTL:    rdata16 = clkctl_q;
      `IDX_READ_PORT: rdata16 = head_data; // RQ20
      default:        rdata16 = 16'h0000;
    endcase
  end

  // Wishbone answer one cycle after the request; every address is acked
  // Trade-off: a registered answer costs a wait state but keeps ack clean
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= req;
      if (rd) begin
        wb_dat_q <= {16'h0000, rdata16};
      end
    end
  end

  assign wb_ack_o          = wb_ack_q;
  assign wb_dat_o          = wb_dat_q;
  assign irq_o             = irq_q;
  assign sampling_active_o = active_q;

  // Checks on the sequencer, the queue and the level flag
  AST_NO_MOVE_WHEN_OFF: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ2
    !clk_en |=> $stable(state_q)) else $error("Mode changed with sample clock off");

  AST_ENTER_PROGRAM: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ3
    (tick_q && clk_en && !stuck_q && mode_q == `MODE_PROGRAM) |=> state_q == ST_PROGRAM)
    else $error("Program not entered");

  AST_ENTER_NORMAL: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ5
    (tick_q && clk_en && !stuck_q && mode_q == `MODE_NORMAL) |=> state_q == ST_NORMAL ##1 sampling_active_o)
    else $error("Normal not entered");

  AST_LOCKED: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ8
    stuck_q |=> stuck_q && $stable(state_q)) else $error("Locked sequencer moved");

  AST_BAD_MODE: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ23
    (wr && idx == `IDX_MODE && wdata16 > `MODE_NORMAL) |=> $stable(mode_q)) else $error("Illegal mode stored");

  AST_FLUSH_EMPTIES: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ7
    flush |=> word_count == 7'h00 && pkt_left_q == 5'h00) else $error("Flush left data");

  AST_WHOLE_PACKET: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ15
    pkt_start |=> (push && word_count <= `QUEUE_WORDS - {2'b00, pkt_left_q})
                  ##1 (word_count <= `QUEUE_WORDS - {2'b00, pkt_left_q})) else $error("Packet overflow");

  AST_COUNT_READ: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ16
    (rd && idx == `IDX_STATUS) |=> wb_ack_o && wb_dat_o[15:8] == {$past(word_count), 1'b0})
    else $error("Byte count wrong");

  AST_POP_CLEARS: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ19
    (pop && !flag_set) |=> !flag_q ##1 !irq_o) else $error("Flag survived read");

  AST_MASKED: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ18
    irq_o |-> $past(flag_q) && !$past(mask_q[`QUEUE_MASK_BIT])) else $error("Interrupt without cause");

  AST_READ_POPS: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ20
    (pop && !push && !flush && word_count != 7'h00) |=> word_count == $past(word_count) - 7'h01)
    else $error("Read did not free a word");

  AST_COUNT_BOUND: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ10
    word_count <= `QUEUE_WORDS)
    else $error("Queue count above capacity");

  AST_STANDBY_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ1
    state_q == ST_STANDBY |=> !sampling_active_o)
    else $error("Sampling flagged in standby");

  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ19
    flag_set |=> flag_q)
    else $error("Level flag lost to a clear");

  AST_LOCK_CAUSE: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ8
    $rose(stuck_q) |-> $past(state_q) != ST_STANDBY)
    else $error("Lock without a running mode");

endmodule // sample_fifo_mode_control

/* rtl/sample_fifo_pkg.sv */
/*
  Types shared by the sample queue and mode control block.
  Assumes the defines header is compiled alongside.
*/
package sample_fifo_pkg;

  // Operating modes of the sequencer
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_PROGRAM,
    ST_NORMAL
  } op_state_t;

  // One 16-bit register
  typedef logic [15:0] reg16_t;

endpackage

/* tb/slot_engine_model.sv */
/*
  Behavioural time slot engine that feeds packets to the sample queue.
  Assumes the bench pulses fire for one cycle and holds the slot words meanwhile.
*/
`timescale 1ns/1ps

module slot_engine_model (
  input  wire logic         core_clk,
  input  wire logic         fire,
  input  wire logic [127:0] a_val,
  input  wire logic [127:0] b_val,
  output logic              rate_event_i,
  output logic      [127:0] slot_a_data_i,
  output logic      [127:0] slot_b_data_i
);
  // Quiet, defined lines at time zero
  initial begin
    rate_event_i = 1'b0;
    slot_a_data_i = 128'h0;
    slot_b_data_i = 128'h0;
  end

  // One event serves both slots, so their output rates always match
  always @(posedge core_clk) begin
    rate_event_i <= fire;
  end

  // Words are valid only with the event; they toggle otherwise so stale data never matches
  always @(posedge core_clk) begin
    slot_a_data_i <= fire ? a_val : ~slot_a_data_i;
    slot_b_data_i <= fire ? b_val : ~slot_b_data_i;
  end
endmodule // slot_engine_model

/* tb/tb_sample_fifo_mode_control.sv */
/*
  Self-checking bench for the sample queue and mode sequencer, acting as host.
  Assumes the defines header and package are compiled ahead of it.
*/
`timescale 1ns/1ps
`include "sample_fifo_defs.svh"

module tb_sample_fifo_mode_control
  import sample_fifo_pkg::*;
;
  logic         core_clk;      // 100 MHz core clock
  logic         arst_n;        // Async reset, low active
  logic         wb_cyc_i;      // Bus cycle
  logic         wb_stb_i;      // Bus strobe
  logic         wb_we_i;       // Write when high
  logic [8:0]   wb_adr_i;      // Byte address
  logic [3:0]   wb_sel_i;      // Byte enables
  logic [31:0]  wb_dat_i;      // Write data
  logic [31:0]  wb_dat_o;      // Read data
  logic         wb_ack_o;      // Bus answer
  logic         rate_event_i;  // Output-rate event
  logic [127:0] slot_a_data_i; // Slot A words
  logic [127:0] slot_b_data_i; // Slot B words
  logic         irq_o;         // Queue interrupt
  logic         sampling_active_o; // Normal mode flag
  logic         fire;          // Ask the engine for a packet
  logic [127:0] a_val;         // Next slot A words
  logic [127:0] b_val;         // Next slot B words
  logic [63:0]  note_q[$];     // Read notes: mask over expected value
  logic [63:0]  note;          // Note under comparison
  logic [15:0]  mq[$];         // Expected queue contents
  int           fail_count;    // Mismatches
  int           checked;       // Comparisons
  int           cyc_cnt = 0;   // Cycles run, for the hang guard

  sample_fifo_mode_control dut (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rate_event_i(rate_event_i),
    .slot_a_data_i(slot_a_data_i), .slot_b_data_i(slot_b_data_i), .irq_o(irq_o),
    .sampling_active_o(sampling_active_o)
  );

  slot_engine_model src (
    .core_clk(core_clk), .fire(fire), .a_val(a_val), .b_val(b_val), .rate_event_i(rate_event_i),
    .slot_a_data_i(slot_a_data_i), .slot_b_data_i(slot_b_data_i)
  );

  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Single compare point; the mask picks the bits that matter
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] msk);
    checked++;
    if (((seen ^ exp) & msk) !== 32'h0000_0000) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; held until ack is sampled, then released for a cycle
  task automatic bus(input logic we, input logic [6:0] idx, input logic [15:0] wd, output logic [31:0] rdat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, wd};
    // No timeout here; if ack never comes, only the hang guard ends this wait
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read with a note for the watcher
  task automatic rd(input logic [6:0] idx, input logic [31:0] exp, input logic [31:0] msk);
    logic [31:0] d;
    note_q.push_back({msk, exp});
    bus(1'b0, idx, 16'h0000, d);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] v);
    logic [31:0] d;
    bus(1'b1, idx, v, d);
  endtask

  // Byte count in the status upper byte
  task automatic cnt_chk();
    rd(`IDX_STATUS, {16'h0000, 8'(2 * mq.size()), 8'h00}, 32'h0000_FF00);
  endtask

  // Pops come back in push order
  task automatic drain(input int n);
    repeat (n)
      rd(`IDX_READ_PORT, {16'h0000, mq.pop_front()}, 32'h0000_FFFF);
  endtask

  // Request a mode, then poll the state until the next sample tick applies it
  task automatic set_mode(input logic [15:0] m);
    logic [31:0] d;
    int n;
    wr(`IDX_MODE, m);
    n = 0;
    d = 32'h0000_0003;
    while (d[1:0] !== m[1:0] && n < 1500) begin
      note_q.push_back(64'h0);
      bus(1'b0, `IDX_MODE_STAT, 16'h0000, d);
      n++;
    end
    rd(`IDX_MODE_STAT, {30'h0, m[1:0]}, 32'h0000_0007);
  endtask

  // One packet; stored only if the whole of it fits
  task automatic ev(input int na, input int nb);
    a_val <= {$urandom, $urandom, $urandom, $urandom};
    b_val <= {$urandom, $urandom, $urandom, $urandom};
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    if (mq.size() + na + nb <= 64) begin
      for (int i = 0; i < na; i++)
        mq.push_back(a_val[16*i +: 16]);
      for (int i = 0; i < nb; i++)
        mq.push_back(b_val[16*i +: 16]);
    end
    repeat (24) @(posedge core_clk);
  endtask

  // Watcher: each read answer is held against the oldest note
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && note_q.size() > 0) begin
      note = note_q.pop_front();
      chk(wb_dat_o, note[31:0], note[63:32]);
    end
  end

  // Hang guard, well above the roughly 50k cycles the sequence needs
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000) begin
      fail_count++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 9'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    fire = 1'b0;
    a_val = 128'h0;
    b_val = 128'h0;
    fail_count = 0;
    checked = 0;
    void'($urandom(32'h1f55_8696));
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(`IDX_MODE, 32'h0000_0000, 32'h0000_FFFF);
    rd(`IDX_MODE_STAT, 32'h0000_0000, 32'h0000_0007);
    rd(`IDX_MASK, 32'h0000_FFFF, 32'hFFFF_FFFF);
    rd(7'h20, 32'h0000_0000, 32'hFFFF_FFFF); // Unmapped place reads zero
    cnt_chk();
    chk({31'h0, sampling_active_o}, 32'h0000_0000, 32'h0000_0001);
    // Mode request with the sample clock stopped must not move
    wr(`IDX_MODE, `MODE_PROGRAM);
    repeat (3200) @(posedge core_clk);
    rd(`IDX_MODE_STAT, 32'h0000_0000, 32'h0000_0007);
    wr(`IDX_CLKCTL, 16'h0080);
    set_mode(`MODE_PROGRAM);
    wr(`IDX_MODE, 16'h0003);
    repeat (3200) @(posedge core_clk);
    rd(`IDX_MODE_STAT, 32'h0000_0001, 32'h0000_0007);
    // Configure while in program: three-word packets, level two, irq unmasked
    wr(`IDX_THRESH, 16'h0200);
    wr(`IDX_MASK, 16'hFEFF);
    wr(`IDX_SELECT, 16'h0012);
    set_mode(`MODE_NORMAL);
    chk({31'h0, sampling_active_o}, 32'h0000_0001, 32'h0000_0001);
    ev(2, 1);
    cnt_chk();
    chk({31'h0, irq_o}, 32'h0000_0001, 32'h0000_0001);
    drain(1);
    chk({31'h0, irq_o}, 32'h0000_0000, 32'h0000_0001);
    drain(2);
    // Fill until a packet is refused, free one, refill, then flush
    repeat (22) ev(2, 1);
    cnt_chk();
    drain(3);
    ev(2, 1);
    cnt_chk();
    wr(`IDX_STATUS, 16'h80FF);
    mq.delete();
    cnt_chk();
    // Every slot format alone, other slot off; last pass has the irq masked
    for (int c = 1; c <= 4; c++) begin
      set_mode(`MODE_PROGRAM);
      wr(`IDX_STATUS, 16'h80FF);
      mq.delete();
      wr(`IDX_THRESH, {2'b00, 6'((1 << (c - 1)) - 1), 8'h00});
      wr(`IDX_MASK, (c == 4) ? 16'hFFFF : 16'hFEFF);
      wr(`IDX_SELECT, {12'h000, 4'(c)});
      set_mode(`MODE_NORMAL);
      ev(1 << (c - 1), 0);
      cnt_chk();
      chk({31'h0, irq_o}, {31'h0, c != 4}, 32'h0000_0001);
      drain(1 << (c - 1));
    end
    // Orderly stop to standby
    set_mode(`MODE_PROGRAM);
    wr(`IDX_STATUS, 16'h00FF);
    set_mode(`MODE_STANDBY);
    chk({31'h0, sampling_active_o}, 32'h0000_0000, 32'h0000_0001);
    // Stopping the clock in standby is legal and must not lock
    wr(`IDX_CLKCTL, 16'h0000);
    rd(`IDX_MODE_STAT, 32'h0000_0000, 32'h0000_0007);
    wr(`IDX_CLKCTL, 16'h0080);
    // Clock stopped outside standby on purpose: sequencer must lock
    set_mode(`MODE_PROGRAM);
    wr(`IDX_CLKCTL, 16'h0000);
    wr(`IDX_MODE, `MODE_STANDBY);
    repeat (3200) @(posedge core_clk);
    rd(`IDX_MODE_STAT, 32'h0000_0005, 32'h0000_0007);
    stop_test();
  end
endmodule // tb_sample_fifo_mode_control
